// ### src/lpcd_pkg.sv
package lpcd_pkg;

  // Fixed identifier and markers of the master request frame
  localparam logic [5:0] ID_MASTER_REQ = 6'h3C;
  localparam logic [7:0] APP_FRAME_MARKER = 8'h80;
  localparam logic [6:0] CMD_LONG_GOAL = 7'h0B;
  localparam logic [7:0] SLEEP_FIRST = 8'h00;
  localparam logic [7:0] SLEEP_FILL = 8'hFF;

  // Frame lengths in data bytes
  localparam logic [3:0] MAX_DATA = 4'h8;
  localparam logic [3:0] LEN_LONG = 4'h8;
  localparam logic [3:0] LEN_C1 = 4'h2;
  localparam logic [3:0] LEN_C2 = 4'h4;
  localparam logic [3:0] LEN_C4 = 4'h8;

  // Field positions inside command, address and identifier bytes
  localparam int CMD_FLAG_BIT = 7;
  localparam int ADDR_FLAG_BIT = 7;
  localparam int BROAD_BIT = 4;
  localparam logic [1:0] ID_TOP_C2 = 2'h2;
  localparam logic [1:0] ID_TOP_C4 = 2'h3;

  // Stepping mode that allows compact goals
  localparam logic [1:0] STEP_HALF = 2'h0;

  // Fallback value that means no fallback is set
  localparam logic [10:0] FALLBACK_NONE = 11'h400;

  // Reset values
  localparam logic [15:0] GOAL_RESET = 16'h0000;

  // Protected identifier: two parity bits above the six id bits
  function automatic logic [7:0] lpcd_prot_id(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction : lpcd_prot_id

  // Sum with end-around carry; checksum is its inverse
  function automatic logic [7:0] lpcd_csum_add(input logic [7:0] acc, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction : lpcd_csum_add

endpackage : lpcd_pkg

// ### src/lpcd_link_if.sv
interface lpcd_link_if;
  logic frame_byte_valid;
  logic [7:0] frame_byte;
  logic frame_byte_last;

  // Bus master drives the frame bytes
  modport master (
    output frame_byte_valid,
    output frame_byte,
    output frame_byte_last
  );

  // Stepper node listens only
  modport node (
    input frame_byte_valid,
    input frame_byte,
    input frame_byte_last
  );
endinterface : lpcd_link_if

// ### src/lpcd_node.sv
// Notes on behaviour
// (R1) Long goal: id 3C, marker 80, command 8B
// (R2) Long goal uses pair matching physical address
// (R3) Long position signed 16-bit, high byte first
// (R4) Compact goals only in half stepping mode
// (R5) Compact address four bits versus OTP id
// (R6) Integrator ties pins and programs OTP suitably
// (R7) Scheme bit selects OTP bit or pin
// (R8) One-motor compact layout: pos, broadcast, address
// (R9) Broadcast flag zero moves every node
// (R10) Two-motor compact: id top 10, two pairs
// (R11) Four-motor compact: id top 11, four pairs
// (R12) Compact position is signed 11-bit goal
// (R13) Identifier parity bits checked by node
// (R14) Compact frames use allocated identifiers
// (R15) Request frame 00 then FF puts sleep
// (R16) Sleep in motion: fallback goal or halt
// (R17) Halt then goal takes current location
// (R18) Bad checksum discards the whole frame
module lpcd_node (
  input wire logic core_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  lpcd_link_if.node link, // Frame bytes from master
  input wire logic [6:0] phys_addr_in, // Node physical address
  input wire logic [3:0] otp_node_id_in, // OTP node identifier
  input wire logic node_id_scheme_bit_in, // Compact address scheme
  input wire logic hard_id_pin2_in, // Hard address pin, async
  input wire logic [1:0] microstep_sel_in, // Stepping mode
  input wire logic [5:0] dyn_id_c1_in, // Allocated id, one motor
  input wire logic [5:0] dyn_id_c2_in, // Allocated id, two motors
  input wire logic [5:0] dyn_id_c4_in, // Allocated id, four motors
  input wire logic [10:0] fallback_location_in, // Fallback goal
  input wire logic [15:0] current_location_reg_in, // Current location
  input wire logic motion_active_in, // Motor is moving
  output logic [15:0] goal_location_reg_out, // Goal location
  output logic goal_load_out, // Goal updated, pulse
  output logic gentle_halt_cmd_out, // Halt request, pulse
  output logic sleep_req_out, // Enter sleep, pulse
  output logic frame_err_out // Frame discarded, pulse
);
  import lpcd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HALT = 2'b10
  } lpcd_state_type;

  lpcd_state_type state_q;
  logic pin2_meta_q;
  logic pin2_q;
  logic [7:0] id_q;
  logic [7:0] data_q [0:7];
  logic [3:0] cnt_q;
  logic [3:0] nd_q;
  logic [7:0] acc_q;
  logic done_q;
  logic ok_q;
  logic [15:0] goal_q;
  logic goal_load_q;
  logic halt_q;
  logic sleep_q;
  logic err_q;

  logic [5:0] id6;
  logic [3:0] eff_id;
  logic is_sleep;
  logic long_hit;
  logic [15:0] long_pos;
  logic cmp_hit;
  logic [10:0] cmp_pos;
  logic [2:0] npairs;

  // Pin is outside the clock domain, so two flops first
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin2_meta_q <= 1'b0;
      pin2_q <= 1'b0;
    end else begin
      pin2_meta_q <= hard_id_pin2_in;
      pin2_q <= pin2_meta_q;
    end
  end

  // Byte collection; extra bytes beyond eight are dropped
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      id_q <= 8'h00;
      cnt_q <= 4'h0;
      acc_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= 8'h00;
      end
    end else if (link.frame_byte_valid) begin
      if (link.frame_byte_last) begin
        cnt_q <= 4'h0;
        acc_q <= 8'h00;
      end else begin
        if (cnt_q == 4'h0) begin
          id_q <= link.frame_byte;
        end else begin
          if (cnt_q <= MAX_DATA) begin
            data_q[cnt_q[2:0] - 3'h1] <= link.frame_byte;
          end
          acc_q <= lpcd_csum_add(acc_q, link.frame_byte);
        end
        if (cnt_q != 4'hF) begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  // Frame end: parity and checksum verdict, one cycle before decode
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
      ok_q <= 1'b0;
      nd_q <= 4'h0;
    end else begin
      done_q <= link.frame_byte_valid & link.frame_byte_last;
      if (link.frame_byte_valid && link.frame_byte_last) begin
        nd_q <= cnt_q - 4'h1;
        // (R13) parity of identifier
        // (R18) checksum over data bytes
        ok_q <= (cnt_q >= 4'h2) && (cnt_q <= MAX_DATA + 4'h1) &&
                (lpcd_prot_id(id_q[5:0]) == id_q) &&
                (~acc_q == link.frame_byte);
      end
    end
  end

  assign id6 = id_q[5:0];

  // (R7) scheme picks OTP bit or synchronised pin for bit 3
  assign eff_id = node_id_scheme_bit_in ? {pin2_q, otp_node_id_in[2:0]} : otp_node_id_in;

  // (R15) sleep frame: first byte 00, rest FF
  always_comb begin
    is_sleep = (id6 == ID_MASTER_REQ) && (nd_q >= 4'h2) && (data_q[0] == SLEEP_FIRST);
    for (int i = 1; i < 8; i++) begin
      if ((4'(i) < nd_q) && (data_q[i] != SLEEP_FILL)) begin
        is_sleep = 1'b0;
      end
    end
  end

  // (R1) long goal frame recognition
  // (R2) only the pair with our physical address counts
  always_comb begin
    long_hit = 1'b0;
    long_pos = 16'h0000;
    if ((id6 == ID_MASTER_REQ) && (nd_q == LEN_LONG) &&
        (data_q[0] == APP_FRAME_MARKER) && data_q[1][CMD_FLAG_BIT] &&
        (data_q[1][6:0] == CMD_LONG_GOAL) &&
        data_q[2][ADDR_FLAG_BIT] && data_q[5][ADDR_FLAG_BIT]) begin
      // (R3) high byte first, signed 16-bit
      if (data_q[2][6:0] == phys_addr_in) begin
        long_hit = 1'b1;
        long_pos = {data_q[3], data_q[4]};
      end else if (data_q[5][6:0] == phys_addr_in) begin
        long_hit = 1'b1;
        long_pos = {data_q[6], data_q[7]};
      end
    end
  end

  // (R14) compact frames known only by allocated ids
  always_comb begin
    npairs = 3'h0;
    if ((id6 == dyn_id_c1_in) && (nd_q == LEN_C1) && (id6[5] == 1'b0)) begin
      npairs = 3'h1;
    end else if ((id6 == dyn_id_c2_in) && (nd_q == LEN_C2) && (id6[5:4] == ID_TOP_C2)) begin
      // (R10) two-motor frame
      npairs = 3'h2;
    end else if ((id6 == dyn_id_c4_in) && (nd_q == LEN_C4) && (id6[5:4] == ID_TOP_C4)) begin
      // (R11) four-motor frame
      npairs = 3'h4;
    end
  end

  // First matching pair wins; other pairs belong to other nodes
  always_comb begin
    cmp_hit = 1'b0;
    cmp_pos = 11'h000;
    for (int k = 3; k >= 0; k--) begin
      // (R5) four-bit address compare
      // (R9) single-motor frame with broadcast flag low
      if ((3'(k) < npairs) &&
          ((data_q[2*k][3:0] == eff_id) ||
           ((npairs == 3'h1) && !data_q[0][BROAD_BIT]))) begin
        cmp_hit = 1'b1;
        // (R8) position bits 10:8 sit in bits 7:5
        cmp_pos = {data_q[2*k][7:5], data_q[2*k+1]};
      end
    end
    // (R4) ignored outside half stepping
    if ((id6 == ID_MASTER_REQ) || (microstep_sel_in != STEP_HALF)) begin
      cmp_hit = 1'b0;
    end
  end

  // Command execution and halt sequence
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      goal_q <= GOAL_RESET;
      goal_load_q <= 1'b0;
      halt_q <= 1'b0;
      sleep_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      goal_load_q <= 1'b0;
      halt_q <= 1'b0;
      sleep_q <= 1'b0;
      err_q <= done_q & ~ok_q;
      case (state_q)
        ST_IDLE: begin
          if (done_q && ok_q) begin
            if (is_sleep) begin
              // (R16) fallback goal or gentle halt first
              if (!motion_active_in) begin
                sleep_q <= 1'b1;
              end else if (fallback_location_in != FALLBACK_NONE) begin
                goal_q <= {{5{fallback_location_in[10]}}, fallback_location_in};
                goal_load_q <= 1'b1;
                sleep_q <= 1'b1;
              end else begin
                halt_q <= 1'b1;
                state_q <= ST_HALT;
              end
            end else if (long_hit) begin
              goal_q <= long_pos;
              goal_load_q <= 1'b1;
            end else if (cmp_hit) begin
              // (R12) sign-extend 11-bit goal
              goal_q <= {{5{cmp_pos[10]}}, cmp_pos};
              goal_load_q <= 1'b1;
            end
          end
        end
        ST_HALT: begin
          // (R17) once stopped, hold the stop position
          // Frames arriving here are dropped: sleep is committed
          if (!motion_active_in) begin
            goal_q <= current_location_reg_in;
            goal_load_q <= 1'b1;
            sleep_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign goal_location_reg_out = goal_q;
  assign goal_load_out = goal_load_q;
  assign gentle_halt_cmd_out = halt_q;
  assign sleep_req_out = sleep_q;
  assign frame_err_out = err_q;

endmodule : lpcd_node

// ### src/lpcd_master.sv
module lpcd_master (
  input wire logic core_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  lpcd_link_if.master link, // Frame bytes to nodes
  input wire logic send_in, // Start frame, pulse
  input wire logic [5:0] frame_id_in, // Unprotected identifier
  input wire logic [3:0] len_in, // Data bytes, 1 to 8
  input wire logic [63:0] data_in, // Data 1 in bits 7:0
  output logic busy_out // Frame in progress
);
  import lpcd_pkg::*;

  typedef enum logic [1:0] {
    M_IDLE = 2'b01,
    M_SEND = 2'b10
  } lpcd_mstate_type;

  lpcd_mstate_type state_q;
  logic [63:0] data_q;
  logic [3:0] len_q;
  logic [3:0] idx_q;
  logic [7:0] acc_q;
  logic valid_q;
  logic [7:0] byte_q;
  logic last_q;
  logic busy_q;

  // One byte per cycle: id, data, checksum
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= M_IDLE;
      data_q <= 64'h0;
      len_q <= 4'h0;
      idx_q <= 4'h0;
      acc_q <= 8'h00;
      valid_q <= 1'b0;
      byte_q <= 8'h00;
      last_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      last_q <= 1'b0;
      case (state_q)
        M_IDLE: begin
          // Refused while the checksum is still out, keeps the idle gap
          busy_q <= 1'b0;
          if (send_in && !busy_q) begin
            busy_q <= 1'b1;
            // (R13) parity bits computed by master
            byte_q <= lpcd_prot_id(frame_id_in);
            valid_q <= 1'b1;
            data_q <= data_in;
            // Length clamped so a frame always carries data
            len_q <= (len_in == 4'h0) ? 4'h1 : ((len_in > MAX_DATA) ? MAX_DATA : len_in);
            idx_q <= 4'h0;
            acc_q <= 8'h00;
            state_q <= M_SEND;
          end
        end
        M_SEND: begin
          valid_q <= 1'b1;
          busy_q <= 1'b1;
          if (idx_q < len_q) begin
            byte_q <= data_q[8*idx_q[2:0] +: 8];
            acc_q <= lpcd_csum_add(acc_q, data_q[8*idx_q[2:0] +: 8]);
            idx_q <= idx_q + 4'h1;
          end else begin
            byte_q <= ~acc_q;
            last_q <= 1'b1;
            state_q <= M_IDLE;
          end
        end
        default: begin
          state_q <= M_IDLE;
        end
      endcase
    end
  end

  assign link.frame_byte_valid = valid_q;
  assign link.frame_byte = byte_q;
  assign link.frame_byte_last = last_q;
  // Busy stays up through the checksum cycle
  assign busy_out = busy_q;

endmodule : lpcd_master

// ### test/lpcd_link_sva.sv
module lpcd_link_sva (
  input wire logic core_clk_in, // System clock
  input wire logic rst_in, // Async reset
  input wire logic frame_byte_valid, // Byte strobe
  input wire logic [7:0] frame_byte, // Byte value
  input wire logic frame_byte_last // Checksum marker
);
  timeunit 1ns;
  timeprecision 1ps;
  logic head_q;
  logic [7:0] acc_q;
  logic [3:0] cnt_q;
  logic [8:0] sum_w;
  assign sum_w = {1'b0, acc_q} + {1'b0, frame_byte};
  // Next strobed byte is an id byte after reset or a checksum
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) head_q <= 1'b1;
    else if (frame_byte_valid) head_q <= frame_byte_last;
  end
  // Running data sum, id byte excluded
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) acc_q <= 8'h00;
    else if (frame_byte_valid) acc_q <= head_q ? 8'h00 : sum_w[7:0] + {7'h00, sum_w[8]};
  end
  // Data bytes seen so far in this frame
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) cnt_q <= 4'h0;
    else if (frame_byte_valid) cnt_q <= head_q ? 4'h0 : cnt_q + 4'h1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_head;
    frame_byte_valid && head_q;
  endsequence
  sequence s_tail;
    frame_byte_valid && frame_byte_last;
  endsequence
  a_id_parity: assert property (s_head |->
    frame_byte[6] == (frame_byte[0] ^ frame_byte[1] ^ frame_byte[2] ^ frame_byte[4]) &&
    frame_byte[7] == ~(frame_byte[1] ^ frame_byte[3] ^ frame_byte[4] ^ frame_byte[5]))
    else $error("id byte parity wrong");
  a_sum_match: assert property (s_tail |-> frame_byte == ~acc_q)
    else $error("checksum byte wrong");
  a_frame_span: assert property (s_head |-> ##[2:9] s_tail)
    else $error("frame length out of range");
  a_head_not_last: assert property (s_head |-> !frame_byte_last)
    else $error("id byte marked last");
  a_last_strobed: assert property (frame_byte_last |-> frame_byte_valid)
    else $error("last without strobe");
  a_idle_gap: assert property (s_tail |=> !frame_byte_valid)
    else $error("no idle cycle after frame");
  a_bytes_packed: assert property (frame_byte_valid && !frame_byte_last |=> frame_byte_valid)
    else $error("gap inside frame");
  a_data_limit: assert property (frame_byte_valid && !head_q && !frame_byte_last |->
    cnt_q < 4'h8) else $error("more than eight data bytes");
endmodule : lpcd_link_sva

// ### test/lin_position_cmd_decoder_test.sv
module lin_position_cmd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic send_in = 1'b0;
  logic [5:0] frame_id_in = 6'h00;
  logic [3:0] len_in = 4'h0;
  logic [63:0] data_in = 64'h0;
  logic busy_out;
  logic scheme = 1'b0;
  // integrator: pin 2 high for scheme 0, OTP bit 0 high
  logic pin2 = 1'b1;
  logic [3:0] otp = 4'h5;
  logic [6:0] phys = 7'h15;
  logic [5:0] id_c1 = 6'h05;
  logic [5:0] id_c2 = 6'h21;
  logic [5:0] id_c4 = 6'h32;
  logic [1:0] step = 2'h0;
  logic [10:0] fb = 11'h400;
  logic [15:0] cur = 16'h1234;
  logic moving = 1'b0;
  logic [15:0] goal;
  logic [15:0] goal_2;
  logic [3:0] fl;
  logic [3:0] fl_2;
  logic [3:0] seen = 4'h0;
  logic [3:0] seen_2 = 4'h0;
  logic seen_clr = 1'b0;
  logic seen_clr_2 = 1'b0;
  int bad_count = 0;
  int checked = 0;
  lpcd_link_if lk();
  lpcd_link_if lk_2();
  // Free-running 200 MHz clock
  always #2.5 core_clk_in = ~core_clk_in;
  lpcd_master u_lpcd_master (.core_clk_in, .rst_in, .link(lk), .send_in, .frame_id_in,
    .len_in, .data_in, .busy_out);
  lpcd_node u_lpcd_node (.core_clk_in, .rst_in, .link(lk), .phys_addr_in(phys),
    .otp_node_id_in(otp), .node_id_scheme_bit_in(scheme), .hard_id_pin2_in(pin2),
    .microstep_sel_in(step), .dyn_id_c1_in(id_c1), .dyn_id_c2_in(id_c2), .dyn_id_c4_in(id_c4),
    .fallback_location_in(fb), .current_location_reg_in(cur), .motion_active_in(moving),
    .goal_location_reg_out(goal), .goal_load_out(fl[3]), .gentle_halt_cmd_out(fl[2]),
    .sleep_req_out(fl[1]), .frame_err_out(fl[0]));
  // Second node fed by hand-made frames, two of the three breaking the wire rules
  lpcd_node u_lpcd_node_2 (.core_clk_in, .rst_in, .link(lk_2), .phys_addr_in(phys),
    .otp_node_id_in(otp), .node_id_scheme_bit_in(scheme), .hard_id_pin2_in(pin2),
    .microstep_sel_in(step), .dyn_id_c1_in(id_c1), .dyn_id_c2_in(id_c2), .dyn_id_c4_in(id_c4),
    .fallback_location_in(fb), .current_location_reg_in(cur), .motion_active_in(moving),
    .goal_location_reg_out(goal_2), .goal_load_out(fl_2[3]), .gentle_halt_cmd_out(fl_2[2]),
    .sleep_req_out(fl_2[1]), .frame_err_out(fl_2[0]));
  lpcd_link_sva u_lpcd_link_sva (.core_clk_in, .rst_in, .frame_byte_valid(lk.frame_byte_valid),
    .frame_byte(lk.frame_byte), .frame_byte_last(lk.frame_byte_last));
  // Pulses last one cycle, so keep them until the next check
  // Cleared through a request so that only this process writes them
  always @(posedge core_clk_in) begin
    seen <= seen_clr ? 4'h0 : (seen | fl);
    seen_2 <= seen_clr_2 ? 4'h0 : (seen_2 | fl_2);
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // Send one frame through the master, then compare flags and goal
  task automatic run(input logic [5:0] id, input logic [3:0] n, input logic [63:0] d,
    input logic [3:0] f, input logic [15:0] g);
    @(posedge core_clk_in);
    #1;
    seen_clr = 1'b1;
    send_in = 1'b1;
    frame_id_in = id;
    len_in = n;
    data_in = d;
    @(posedge core_clk_in);
    #1;
    seen_clr = 1'b0;
    send_in = 1'b0;
    check({15'h0000, busy_out}, 16'h0001);
    for (int i = 0; i < 20 && busy_out; i++) begin
      @(posedge core_clk_in);
      #1;
    end
    check({15'h0000, busy_out}, 16'h0000);
    repeat (4) @(posedge core_clk_in);
    #1;
    check({12'h000, seen}, {12'h000, f});
    check(goal, g);
  endtask : run
  // Two-byte frame driven straight onto the second link
  task automatic raw(input logic [7:0] pid, input logic [7:0] d1, input logic [7:0] d2,
    input logic [7:0] cs, input logic [3:0] f);
    logic [7:0] b [4];
    b = '{pid, d1, d2, cs};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      #1;
      seen_clr_2 = (i == 0);
      lk_2.frame_byte_valid = 1'b1;
      lk_2.frame_byte = b[i];
      lk_2.frame_byte_last = (i == 3);
    end
    @(posedge core_clk_in);
    #1;
    lk_2.frame_byte_valid = 1'b0;
    lk_2.frame_byte_last = 1'b0;
    lk_2.frame_byte = ~lk_2.frame_byte;
    repeat (4) @(posedge core_clk_in);
    #1;
    check({12'h000, seen_2}, {12'h000, f});
  endtask : raw
  // Main sequence
  initial begin
    lk_2.frame_byte_valid = 1'b0;
    lk_2.frame_byte = 8'h00;
    lk_2.frame_byte_last = 1'b0;
    repeat (6) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    raw(8'h85, 8'hB5, 8'h23, 8'h27, 4'h8); // good frame
    check(goal_2, 16'hFD23); // compact goal
    raw(8'h85, 8'hB5, 8'h24, 8'h27, 4'h1); // bad checksum
    raw(8'h45, 8'hB5, 8'h23, 8'h27, 4'h1); // bad parity
    check(goal_2, 16'hFD23); // goal untouched
    run(6'h3C, 4'h8, 64'hDCFE95AAAA918B80, 4'h8, 16'hFEDC); // second pair
    run(6'h3C, 4'h8, 64'hDCFE95AAAA918B81, 4'h0, 16'hFEDC); // wrong marker
    run(6'h3C, 4'h8, 64'h0000913412958B80, 4'h8, 16'h1234); // first pair
    run(6'h05, 4'h2, 64'h23B5, 4'h8, 16'hFD23); // own address
    run(6'h05, 4'h2, 64'h00B6, 4'h0, 16'hFD23); // other address
    run(6'h05, 4'h2, 64'h1126, 4'h8, 16'h0111); // broadcast
    step = 2'h1;
    run(6'h05, 4'h2, 64'h23B5, 4'h0, 16'h0111); // not half stepping
    step = 2'h0;
    run(6'h21, 4'h4, 64'h44750013, 4'h8, 16'h0344); // two motors
    run(6'h32, 4'h8, 64'h01F5007300720071, 4'h8, 16'hFF01); // four motors
    run(6'h06, 4'h2, 64'h23B5, 4'h0, 16'hFF01); // unallocated id
    scheme = 1'b1;
    run(6'h05, 4'h2, 64'h00B5, 4'h0, 16'hFF01); // pin bit mismatch
    run(6'h05, 4'h2, 64'h02BD, 4'h8, 16'hFD02); // pin bit match
    pin2 = 1'b0;
    run(6'h05, 4'h2, 64'h03B5, 4'h8, 16'hFD03); // pin low
    pin2 = 1'b1;
    scheme = 1'b0;
    run(6'h3C, 4'h2, 64'hFF00, 4'h2, 16'hFD03); // sleep at rest
    moving = 1'b1;
    fb = 11'h2AB;
    run(6'h3C, 4'h2, 64'hFF00, 4'hA, 16'h02AB); // fallback goal
    fb = 11'h400;
    run(6'h3C, 4'h2, 64'hFF00, 4'h4, 16'h02AB); // halt first
    moving = 1'b0;
    seen_clr = 1'b1;
    @(posedge core_clk_in);
    #1;
    seen_clr = 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    check({12'h000, seen}, 16'h000A); // sleep after stop
    check(goal, 16'h1234); // goal takes current
    complete_run();
  end
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule : lin_position_cmd_decoder_test
